//--- rtl/irqlg_regs.vh
/*
 Register map, field positions, reset values and edge codes of the
 interrupt request logic.
 Assumes APB with 32-bit data; each 4-bit register sits in the low
 bits of one aligned word at byte address four times its index.
*/
`ifndef IRQLG_REGS_VH
`define IRQLG_REGS_VH

// Register indexes; byte address is index * 4
`define IRQLG_IDX_CTRL0       10'h000
`define IRQLG_IDX_CTRL1       10'h001
`define IRQLG_IDX_EXT23       10'h022
`define IRQLG_IDX_EXT4        10'h023
`define IRQLG_IDX_EDGE_ONE    10'h026
`define IRQLG_IDX_EDGE_TWO    10'h027
`define IRQLG_ADDR_W          12

// Index 0x000 fields
`define IRQLG_BIT_GIE         0
`define IRQLG_BIT_FLAG0       2
`define IRQLG_BIT_MASK0       3
// Index 0x001 fields
`define IRQLG_BIT_FLAG1       0
`define IRQLG_BIT_MASK1       1
`define IRQLG_BIT_TA_FLAG     2
`define IRQLG_BIT_TA_MASK     3
// Index 0x022 fields
`define IRQLG_BIT_FLAG2       0
`define IRQLG_BIT_MASK2       1
`define IRQLG_BIT_FLAG3       2
`define IRQLG_BIT_MASK3       3
// Index 0x023 fields
`define IRQLG_BIT_FLAG4       0
`define IRQLG_BIT_MASK4       1

// Edge select fields
`define IRQLG_ESEL_LO         1:0
`define IRQLG_ESEL_HI         3:2
`define IRQLG_ESEL_RST        4'h0

// Edge codes
`define IRQLG_EDGE_NONE       2'h0
`define IRQLG_EDGE_FALL       2'h1
`define IRQLG_EDGE_RISE       2'h2
`define IRQLG_EDGE_BOTH       2'h3

// Reset values
`define IRQLG_GIE_RST         1'h0
`define IRQLG_FLAG_RST        1'h0
`define IRQLG_MASK_RST        1'h1

// Priority slots, highest first
`define IRQLG_NUM_SRC         7
`define IRQLG_SLOT_NONE       3'h7

`endif

//--- rtl/irqlg_pin_edge.v
/*
 Pin synchroniser and programmable edge detector.
 Assumes the pin is asynchronous to clock; the edge code is static
 or changes only from clock-domain logic.
*/
`timescale 1ns/1ps
`include "irqlg_regs.vh"

module irqlg_pin_edge (
    // Clock and reset
    input  wire       clock,
    input  wire       arst_n,
    // Pin and edge choice
    input  wire       pin,
    input  wire [1:0] edge_sel,
    // One-cycle edge event
    output reg        edge_pulse
);

    reg sync_a;
    reg sync_b;
    reg prev;

    wire rise = sync_b & ~prev;
    wire fall = ~sync_b & prev;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync_a     <= 1'b0;
            sync_b     <= 1'b0;
            prev       <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            sync_a     <= pin;
            sync_b     <= sync_a;
            prev       <= sync_b;
            // Code 00 ignores both edges
            edge_pulse <= (edge_sel[0] & fall) | (edge_sel[1] & rise);
        end
    end

endmodule

//--- rtl/irqlg_top.v
/*
 Interrupt request logic: pin edge detection, request flags, masks,
 global enable, fixed-priority selection and the APB register slave.
 Assumes one clock; the CPU sequencer pulses irq_taken when it enters
 a handler and return_from_interrupt_instr_exec when the return instruction runs; the timer
 and serial request inputs come from logic on the same clock.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "irqlg_regs.vh"

// Contract
// - Seven sources are ranked ext0, ext1, timer A, ext2, timer C or ext3, timer D or ext4, serial.
// - The global enable at bit 0 of index 0x000 blocks all requests when 0.
// - Taking an interrupt clears the global enable and the return instruction sets it.
// - A falling edge on pin zero or one sets its request flag.
// - Flags two to four are set by the edge chosen in the edge select registers.
// - Edge select one holds ext3 edge in bits 3:2 and ext2 edge in bits 1:0.
// - Edge select two holds capture edge in bits 3:2 and ext4 edge in bits 1:0.
// - Each external flag has a mask; 1 blocks the request but keeps the flag.
// - Timer A overflow sets the timer A flag at bit 2 of index 0x001.
// - The timer A mask at bit 3 of index 0x001 blocks timer A requests when 1.
// - Both edge select registers are 4-bit write-only and reset to zero.
module irqlg_top (
    // Clock and reset
    input  wire                     clock,
    input  wire                     arst_n,
    // APB slave
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`IRQLG_ADDR_W-1:0] paddr,
    input  wire [31:0]              pwdata,
    input  wire [3:0]               pstrb,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    // Interrupt pins
    input  wire                     ext_irq_pin_zero,
    input  wire                     ext_irq_pin_one,
    input  wire                     ext_irq_pin_two,
    input  wire                     ext_irq_pin_three,
    input  wire                     ext_irq_pin_four,
    input  wire                     capture_event_input,
    // On-chip sources
    input  wire                     timer_a_overflow,
    input  wire                     timer_c_request,
    input  wire                     timer_d_request,
    input  wire                     serial_request,
    // CPU sequencer
    input  wire                     irq_taken,
    input  wire                     return_from_interrupt_instr_exec,
    output reg                      irq_request,
    output reg  [2:0]               irq_slot,
    output reg                      global_irq_enable,
    // Capture edge for the timer
    output reg                      capture_edge
);

    ////////////////////////////////////////////////////////////////////
    // State

    reg [4:0] external_request_flags;
    reg [4:0] external_request_masks;
    reg       timer_a_overflow_flag;
    reg       timer_a_overflow_mask;
    reg [3:0] edge_select_one;
    reg [3:0] edge_select_two;

    wire [4:0] pin_edge;
    wire       capture_pulse;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Lowest set bit wins, slot 0 being the highest priority
    function [2:0] first_slot;
        input [`IRQLG_NUM_SRC-1:0] pend;
        integer i;
        begin
            first_slot = `IRQLG_SLOT_NONE;
            for (i = `IRQLG_NUM_SRC - 1; i >= 0; i = i - 1) begin
                if (pend[i]) begin
                    first_slot = i[2:0];
                end
            end
        end
    endfunction

    // Word index from a byte address; misaligned gives an unused index
    function [9:0] word_index;
        input [`IRQLG_ADDR_W-1:0] addr;
        begin
            if (addr[1:0] != 2'h0) begin
                word_index = 10'h3FF;
            end else begin
                word_index = addr[`IRQLG_ADDR_W-1:2];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin edge detection

    irqlg_pin_edge u_edge0 (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (ext_irq_pin_zero),
        .edge_sel   (`IRQLG_EDGE_FALL),
        .edge_pulse (pin_edge[0])
    );

    irqlg_pin_edge u_edge1 (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (ext_irq_pin_one),
        .edge_sel   (`IRQLG_EDGE_FALL),
        .edge_pulse (pin_edge[1])
    );

    irqlg_pin_edge u_edge2 (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (ext_irq_pin_two),
        .edge_sel   (edge_select_one[`IRQLG_ESEL_LO]),
        .edge_pulse (pin_edge[2])
    );

    irqlg_pin_edge u_edge3 (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (ext_irq_pin_three),
        .edge_sel   (edge_select_one[`IRQLG_ESEL_HI]),
        .edge_pulse (pin_edge[3])
    );

    irqlg_pin_edge u_edge4 (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (ext_irq_pin_four),
        .edge_sel   (edge_select_two[`IRQLG_ESEL_LO]),
        .edge_pulse (pin_edge[4])
    );

    irqlg_pin_edge u_edge_cap (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (capture_event_input),
        .edge_sel   (edge_select_two[`IRQLG_ESEL_HI]),
        .edge_pulse (capture_pulse)
    );

    ////////////////////////////////////////////////////////////////////
    // APB decode

    wire [9:0] acc_idx  = word_index(paddr);
    wire       acc_done = psel & penable & pready;
    wire       wr_lane0 = acc_done & pwrite & pstrb[0];

    reg        hit;
    reg [3:0]  rd_nibble;

    // Edge select registers read as zero since they are write-only
    always @* begin
        hit       = 1'b1;
        rd_nibble = 4'h0;
        if (acc_idx == `IRQLG_IDX_CTRL0) begin
            rd_nibble[`IRQLG_BIT_GIE]   = global_irq_enable;
            rd_nibble[`IRQLG_BIT_FLAG0] = external_request_flags[0];
            rd_nibble[`IRQLG_BIT_MASK0] = external_request_masks[0];
        end else if (acc_idx == `IRQLG_IDX_CTRL1) begin
            rd_nibble[`IRQLG_BIT_FLAG1]   = external_request_flags[1];
            rd_nibble[`IRQLG_BIT_MASK1]   = external_request_masks[1];
            rd_nibble[`IRQLG_BIT_TA_FLAG] = timer_a_overflow_flag;
            rd_nibble[`IRQLG_BIT_TA_MASK] = timer_a_overflow_mask;
        end else if (acc_idx == `IRQLG_IDX_EXT23) begin
            rd_nibble[`IRQLG_BIT_FLAG2] = external_request_flags[2];
            rd_nibble[`IRQLG_BIT_MASK2] = external_request_masks[2];
            rd_nibble[`IRQLG_BIT_FLAG3] = external_request_flags[3];
            rd_nibble[`IRQLG_BIT_MASK3] = external_request_masks[3];
        end else if (acc_idx == `IRQLG_IDX_EXT4) begin
            rd_nibble[`IRQLG_BIT_FLAG4] = external_request_flags[4];
            rd_nibble[`IRQLG_BIT_MASK4] = external_request_masks[4];
        end else if (acc_idx == `IRQLG_IDX_EDGE_ONE) begin
            rd_nibble = 4'h0;
        end else if (acc_idx == `IRQLG_IDX_EDGE_TWO) begin
            rd_nibble = 4'h0;
        end else begin
            hit = 1'b0;
        end
    end

    wire wr_ctrl0 = wr_lane0 & (acc_idx == `IRQLG_IDX_CTRL0);
    wire wr_ctrl1 = wr_lane0 & (acc_idx == `IRQLG_IDX_CTRL1);
    wire wr_ext23 = wr_lane0 & (acc_idx == `IRQLG_IDX_EXT23);
    wire wr_ext4  = wr_lane0 & (acc_idx == `IRQLG_IDX_EXT4);
    wire wr_edge_select_one  = wr_lane0 & (acc_idx == `IRQLG_IDX_EDGE_ONE);
    wire wr_edge_select_two  = wr_lane0 & (acc_idx == `IRQLG_IDX_EDGE_TWO);

    // One wait state: pready rises in the second access cycle
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= {28'h000_0000, rd_nibble};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags, masks, edge selects

    reg [4:0] next_flags;
    reg [4:0] next_masks;
    reg       next_ta_flag;
    reg       next_ta_mask;

    always @* begin
        next_flags   = external_request_flags;
        next_masks   = external_request_masks;
        next_ta_flag = timer_a_overflow_flag;
        next_ta_mask = timer_a_overflow_mask;
        // Software writes first, so a same-cycle event still sets
        if (wr_ctrl0) begin
            next_flags[0] = pwdata[`IRQLG_BIT_FLAG0];
            next_masks[0] = pwdata[`IRQLG_BIT_MASK0];
        end
        if (wr_ctrl1) begin
            next_flags[1] = pwdata[`IRQLG_BIT_FLAG1];
            next_masks[1] = pwdata[`IRQLG_BIT_MASK1];
            next_ta_flag  = pwdata[`IRQLG_BIT_TA_FLAG];
            next_ta_mask  = pwdata[`IRQLG_BIT_TA_MASK];
        end
        if (wr_ext23) begin
            next_flags[2] = pwdata[`IRQLG_BIT_FLAG2];
            next_masks[2] = pwdata[`IRQLG_BIT_MASK2];
            next_flags[3] = pwdata[`IRQLG_BIT_FLAG3];
            next_masks[3] = pwdata[`IRQLG_BIT_MASK3];
        end
        if (wr_ext4) begin
            next_flags[4] = pwdata[`IRQLG_BIT_FLAG4];
            next_masks[4] = pwdata[`IRQLG_BIT_MASK4];
        end
        next_flags = next_flags | pin_edge;
        if (timer_a_overflow) begin
            next_ta_flag = 1'b1;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            external_request_flags <= {5{`IRQLG_FLAG_RST}};
            external_request_masks <= {5{`IRQLG_MASK_RST}};
            timer_a_overflow_flag  <= `IRQLG_FLAG_RST;
            timer_a_overflow_mask  <= `IRQLG_MASK_RST;
            edge_select_one        <= `IRQLG_ESEL_RST;
            edge_select_two        <= `IRQLG_ESEL_RST;
        end else begin
            external_request_flags <= next_flags;
            external_request_masks <= next_masks;
            timer_a_overflow_flag  <= next_ta_flag;
            timer_a_overflow_mask  <= next_ta_mask;
            if (wr_edge_select_one) begin
                edge_select_one <= pwdata[3:0];
            end
            if (wr_edge_select_two) begin
                edge_select_two <= pwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Global enable

    // A take in the same cycle as a write or return leaves it cleared
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            global_irq_enable <= `IRQLG_GIE_RST;
        end else if (irq_taken) begin
            global_irq_enable <= 1'b0;
        end else if (return_from_interrupt_instr_exec) begin
            global_irq_enable <= 1'b1;
        end else if (wr_ctrl0) begin
            global_irq_enable <= pwdata[`IRQLG_BIT_GIE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Priority selection

    wire [4:0] ext_live = external_request_flags & ~external_request_masks;
    wire       ta_live  = timer_a_overflow_flag & ~timer_a_overflow_mask;

    wire [`IRQLG_NUM_SRC-1:0] pending = {
        serial_request,
        ext_live[4] | timer_d_request,
        ext_live[3] | timer_c_request,
        ext_live[2],
        ta_live,
        ext_live[1],
        ext_live[0]
    };

    // Request drops in the cycle after a take, since irq_taken gates it directly
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_request  <= 1'b0;
            irq_slot     <= `IRQLG_SLOT_NONE;
            capture_edge <= 1'b0;
        end else begin
            irq_request  <= global_irq_enable & ~irq_taken & (|pending);
            irq_slot     <= first_slot(pending);
            capture_edge <= capture_pulse;
        end
    end

endmodule

//--- dv/irqlg_assertions.sv
/*
 Concurrent checks on the ports of the interrupt request logic.
 Assumes it is bound to irqlg_top and that all logic runs on clock.
*/
`timescale 1ns/1ps
`include "irqlg_regs.vh"

module irqlg_assertions (
    // Clock and reset
    input wire                     clock,
    input wire                     arst_n,
    // APB
    input wire                     psel,
    input wire                     penable,
    input wire                     pwrite,
    input wire [`IRQLG_ADDR_W-1:0] paddr,
    input wire [31:0]              prdata,
    input wire                     pready,
    input wire                     pslverr,
    // Pins and CPU
    input wire                     capture_event_input,
    input wire                     capture_edge,
    input wire                     irq_taken,
    input wire                     return_from_interrupt_instr_exec,
    input wire                     irq_request,
    input wire [2:0]               irq_slot,
    input wire                     global_irq_enable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        pready ##1 !pready;
    endsequence
    property p_access;
        s_wait |=> s_done;
    endproperty

    ////////////////////////////////////////////////////////////////////////
    a_access_one_wait: assert property (p_access)
        else $error("access phase did not end after one wait");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside a transfer");
    a_misaligned_error: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_edge_sel_hidden: assert property (pready && !pwrite &&
        (paddr[11:2] == `IRQLG_IDX_EDGE_ONE || paddr[11:2] == `IRQLG_IDX_EDGE_TWO)
        |-> prdata == 32'h0 && !pslverr)
        else $error("edge select register readable");
    a_request_needs_enable: assert property (irq_request |->
        global_irq_enable || $past(global_irq_enable))
        else $error("request raised while disabled");
    a_taken_clears_enable: assert property (irq_taken |=>
        !global_irq_enable && !irq_request)
        else $error("taking did not clear the enable");
    a_return_sets_enable: assert property (return_from_interrupt_instr_exec && !irq_taken |=>
        global_irq_enable)
        else $error("return did not set the enable");
    a_request_has_slot: assert property (irq_request |->
        irq_slot != `IRQLG_SLOT_NONE)
        else $error("request without a source slot");
    a_capture_from_pin: assert property (capture_edge |->
        $past(capture_event_input, 3) != $past(capture_event_input, 4) ||
        $past(capture_event_input, 4) != $past(capture_event_input, 5))
        else $error("capture edge without a pin change");
endmodule

//--- dv/irqlg_cpu_model.sv
/*
 Behavioural CPU sequencer: takes a request after a chosen delay and
 runs the return instruction when the bench says the handler is done.
 Assumes same clock and reset as the interrupt logic.
*/
`timescale 1ns/1ps

module irqlg_cpu_model (
    // Clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // Request side
    input  wire        irq_request,
    input  wire [2:0]  irq_slot,
    input  wire [3:0]  delay,
    input  wire        ret,
    // Sequencer outputs
    output logic       irq_taken,
    output logic       return_from_interrupt_instr_exec,
    output logic [2:0] taken_slot,
    output int         taken_cnt
);
    logic       in_handler;
    logic [3:0] wait_n;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_taken  <= 1'b0;
            return_from_interrupt_instr_exec  <= 1'b0;
            in_handler <= 1'b0;
            wait_n     <= 4'h0;
            taken_slot <= 3'h7;
            taken_cnt  <= 0;
        end else begin
            irq_taken <= 1'b0;
            return_from_interrupt_instr_exec <= 1'b0;
            // A request that drops before the delay ends is not taken
            if (!in_handler && irq_request) begin
                if (wait_n == delay) begin
                    irq_taken  <= 1'b1;
                    in_handler <= 1'b1;
                    taken_slot <= irq_slot;
                    taken_cnt  <= taken_cnt + 1;
                    wait_n     <= 4'h0;
                end else begin
                    wait_n <= wait_n + 4'h1;
                end
            end else if (!in_handler) begin
                wait_n <= 4'h0;
            end
            if (in_handler && ret) begin
                return_from_interrupt_instr_exec  <= 1'b1;
                in_handler <= 1'b0;
            end
        end
    end
endmodule

//--- dv/testbench.sv
/*
 Self-checking bench: APB register access, pin edges, CPU model.
 Assumes irqlg_top, the register header and the CPU model.
*/
`timescale 1ns/1ps
`include "irqlg_regs.vh"

module testbench;
    localparam logic [11:0] A0  = {`IRQLG_IDX_CTRL0, 2'b00};
    localparam logic [11:0] A1  = {`IRQLG_IDX_CTRL1, 2'b00};
    localparam logic [11:0] A22 = {`IRQLG_IDX_EXT23, 2'b00};
    localparam logic [11:0] A23 = {`IRQLG_IDX_EXT4, 2'b00};
    localparam logic [11:0] AE1 = {`IRQLG_IDX_EDGE_ONE, 2'b00};
    localparam logic [11:0] AE2 = {`IRQLG_IDX_EDGE_TWO, 2'b00};
    logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic        pready, pslverr, erv, pz = 1, p1 = 1, ta = 0, ret = 0;
    logic [3:0]  ep = 0, delay = 0;
    logic [2:0]  oth = 0;
    logic        irq_taken, return_from_interrupt_instr_exec, irq_request, global_irq_enable, capture_edge;
    logic [2:0]  irq_slot, taken_slot;
    int          taken_cnt, cap_n = 0, errors = 0, tests_run = 0;

    irqlg_top irqlg_top_inst (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .ext_irq_pin_zero(pz),
        .ext_irq_pin_one(p1), .ext_irq_pin_two(ep[0]), .ext_irq_pin_three(ep[1]),
        .ext_irq_pin_four(ep[2]), .capture_event_input(ep[3]), .timer_a_overflow(ta),
        .timer_c_request(oth[0]), .timer_d_request(oth[1]), .serial_request(oth[2]),
        .irq_taken, .return_from_interrupt_instr_exec, .irq_request, .irq_slot, .global_irq_enable,
        .capture_edge);
    irqlg_cpu_model irqlg_cpu_model_inst (.clock, .arst_n, .irq_request, .irq_slot,
        .delay, .ret, .irq_taken, .return_from_interrupt_instr_exec, .taken_slot, .taken_cnt);

    initial forever #2.5 clock = ~clock;
    always @(posedge clock) if (capture_edge === 1'b1) cap_n <= cap_n + 1;

    ////////////////////////////////////////////////////////////////////////
    task cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errors++;
        rdv = prdata;
        erv = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task chk(input logic [11:0] a, input logic [31:0] x); apb(0, a, 0); cmp(rdv, x); endtask
    task wait_take(input int k);
        int n;
        for (n = 0; n < 200 && taken_cnt != k; n++) @(posedge clock);
        if (taken_cnt != k) errors++;
        repeat (2) @(posedge clock);
    endtask
    task do_ret();
        int n;
        ret <= 1;
        for (n = 0; n < 50 && return_from_interrupt_instr_exec !== 1'b1; n++) @(posedge clock);
        if (return_from_interrupt_instr_exec !== 1'b1) errors++;
        ret <= 0;
        repeat (2) @(posedge clock);
    endtask
    task edge_case(input int s, input logic [1:0] c);
        logic [11:0] fa;
        logic [31:0] base, bitv;
        int k, c0;
        fa = s < 2 ? A22 : A23;
        base = s < 2 ? 32'hA : 32'h2;
        bitv = s == 1 ? 32'h4 : 32'h1;
        wr(s < 2 ? AE1 : AE2, {30'h0, c} << (2 * (s % 2)));
        for (k = 0; k < 2; k++) begin
            c0 = cap_n;
            ep[s] <= (k == 0);
            repeat (8) @(posedge clock);
            if (s == 3) cmp(32'(cap_n - c0), {31'h0, c[1-k]});
            else chk(fa, base | (c[1-k] ? bitv : 32'h0));
            wr(fa, base);
        end
    endtask
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1;
        chk(A0, 32'h8);
        chk(A1, 32'hA);
        chk(A22, 32'hA);
        chk(A23, 32'h2);
        chk(AE1, 32'h0);
        apb(0, 12'h010, 0);
        cmp(erv, 1);
        apb(1, 12'h002, 32'hF);
        cmp(erv, 1);
        chk(A0, 32'h8);
        $display("test reset values done");
        pz <= 0;
        repeat (8) @(posedge clock);
        chk(A0, 32'hC);
        cmp(irq_request, 0);
        pz <= 1;
        wr(A0, 32'h5);
        wait_take(1);
        cmp(taken_slot, 0);
        cmp(global_irq_enable, 0);
        chk(A0, 32'h4);
        wr(A0, 32'h0);
        do_ret();
        cmp(global_irq_enable, 1);
        cmp(irq_request, 0);
        $display("test ext0 service done");
        delay <= 5;
        wr(A0, 32'h0);
        wr(A1, 32'h0);
        p1 <= 0; ta <= 1;
        @(posedge clock);
        ta <= 0;
        repeat (8) @(posedge clock);
        cmp(irq_slot, 1);
        cmp(irq_request, 0);
        chk(A1, 32'h5);
        wr(A0, 32'h1);
        wait_take(2);
        cmp(taken_slot, 1);
        wr(A1, 32'h4);
        p1 <= 1;
        do_ret();
        wait_take(3);
        cmp(taken_slot, 2);
        wr(A1, 32'hC);
        do_ret();
        repeat (4) @(posedge clock);
        cmp(irq_request, 0);
        chk(A1, 32'hC);
        wr(A1, 32'h8);
        wr(A0, 32'h0);
        wr(A22, 32'h9);
        oth <= 3'h7;
        repeat (3) @(posedge clock);
        cmp(irq_slot, 3);
        cmp(irq_request, 0);
        wr(A22, 32'hA);
        repeat (2) @(posedge clock);
        cmp(irq_slot, 4);
        oth <= 3'h6;
        repeat (3) @(posedge clock);
        cmp(irq_slot, 5);
        oth <= 3'h4;
        repeat (3) @(posedge clock);
        cmp(irq_slot, 6);
        oth <= 3'h0;
        $display("test priority and masks done");
        for (int s = 0; s < 4; s++)
            for (int c = 0; c < 4; c++) edge_case(s, c[1:0]);
        $display("test edge selects done");
        tally_and_finish();
    end
endmodule

bind irqlg_top irqlg_assertions irqlg_assertions_inst (.clock, .arst_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .capture_event_input, .capture_edge,
    .irq_taken, .return_from_interrupt_instr_exec, .irq_request, .irq_slot, .global_irq_enable);
